/* File: logic/slcr_pkg.sv */
// Shared constants and carrier types of the sweep and list configuration block
package slcr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BEGIN = 8'h06;
  localparam logic [7:0] IDX_STOP = 8'h07;
  localparam logic [7:0] IDX_STEP = 8'h08;
  localparam logic [7:0] IDX_DWELL = 8'h09;
  localparam logic [7:0] IDX_CYCLES = 8'h0a;
  localparam logic [7:0] IDX_RSVD = 8'h0b;
  localparam logic [7:0] IDX_POINTS = 8'h0c;
  localparam logic [7:0] IDX_LOAD = 8'h0d;
  localparam logic [7:0] IDX_UPPER = 8'h20;
  localparam logic [7:0] IDX_CTRL = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;

  localparam int unsigned WORD_W = 56;
  localparam int unsigned PAY_W = 54;
  localparam int unsigned UPPER_W = 24;
  localparam int unsigned DWELL_W = 32;
  localparam int unsigned CYCLE_W = 32;
  localparam int unsigned POINTS_W = 16;
  localparam int unsigned PTR_STAT_W = 12;

  localparam logic [1:0] TAG_FREQ = 2'h0;
  localparam logic [1:0] TAG_DWELL = 2'h1;
  localparam logic [1:0] TAG_AMP = 2'h2;
  localparam logic [1:0] TAG_END = 2'h3;
  localparam logic [55:0] LOAD_RESET_WORD = 56'h00000000000000;
  localparam logic [55:0] LOAD_END_WORD = 56'hffffffffffffff;

  localparam int unsigned LIST_DEPTH = 2048;
  localparam int unsigned DWELL_UNIT_US = 500;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DWELL_TICK_CYCLES = DWELL_UNIT_US * CLK_MHZ;

  localparam logic [55:0] WORD_RESET = 56'h00000000000000;
  localparam logic [31:0] DATA_RESET = 32'h00000000;

  typedef struct packed {
    logic [1:0] tag;
    logic [53:0] payload;
  } slcr_entry_s;

  typedef struct packed {
    logic stepOnTrig;
    logic listMode;
    logic reverse;
    logic run;
  } slcr_ctrl_s;

  localparam slcr_ctrl_s CTRL_RESET = '{stepOnTrig: 1'b0, listMode: 1'b0, reverse: 1'b0,
                                         run: 1'b0};

  typedef struct packed {
    logic [15:0] points;
    logic unused;
    logic active;
    logic terminated;
    logic armed;
    logic [11:0] ptr;
  } slcr_status_s;

  typedef enum logic [1:0] {
    LD_IDLE = 2'h0,
    LD_ARMED = 2'h1,
    LD_DONE = 2'h3
  } slcr_load_e;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'h0,
    SQ_SHOW = 2'h1,
    SQ_WAIT = 2'h3,
    SQ_NEXT = 2'h2
  } slcr_seq_e;
endpackage

/* File: logic/slcr_dwell_timer.sv */
// Dwell interval timer: prescaled 500 us ticks, reloaded per step
`timescale 1ns/1ps
module slcr_dwell_timer #(
  parameter int unsigned TICK_CYCLES = slcr_pkg::DWELL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [31:0] units,
  output logic done
);
  localparam int unsigned PRE_W = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  logic [PRE_W-1:0] pre_q, pre_d;
  logic [31:0] left_q, left_d;
  logic done_q, done_d;

  always_comb begin
    pre_d = pre_q;
    left_d = left_q;
    done_d = done_q;
    if (load) begin
      pre_d = '0;
      left_d = units;
      done_d = 1'b0;
    end else if (left_q == 32'h0) begin
      done_d = 1'b1;
    end else if (pre_q == PRE_W'(TICK_CYCLES - 1)) begin
      pre_d = '0;
      left_d = left_q - 32'h1;
    end else begin
      pre_d = pre_q + PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
      left_q <= 32'h0;
      done_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      left_q <= left_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
endmodule // slcr_dwell_timer

/* File: logic/slcr_regs.sv */
// Sweep and list configuration registers with list loader and step sequencer
// Operation
// (RULE1) Stop frequency held in 56-bit register
// (RULE2) Host keeps start below stop frequency
// (RULE3) 56-bit step; host keeps step within span
// (RULE4) Dwell uses low 32 bits, 500 us units
// (RULE5) Zero cycles repeats forever, else exact count
// (RULE6) Point count register overrides loaded count
// (RULE7) Host keeps point count within loaded entries
// (RULE8) Host loads frequency then amplitude pairs
// (RULE9) Word: 54-bit payload, 2-bit type tag
// (RULE10) Frequency in mHz, amplitude in centi-dBm
// (RULE11) All-zero load write rewinds and arms pointer
// (RULE12) Nonzero writes store and advance to 2047; the pointer here stops at LIST_DEPTH (2048)
// (RULE13) All-ones tag-3 word ends load, freezes pointer
// (RULE14) Frozen pointer becomes active point count
// (RULE15) Direction picks start end and step sense
// (RULE16) Dwell counter prescaled from system clock
// (RULE17) Writes after termination ignored until rewind
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module slcr_regs #(
  parameter int unsigned LIST_DEPTH = slcr_pkg::LIST_DEPTH,
  parameter int unsigned DWELL_TICK_CYCLES = slcr_pkg::DWELL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigPin,
  output logic [55:0] freqMilliHz,
  output logic [53:0] ampCentiDbm,
  output logic sweepActive
);
  localparam int unsigned IDX_W = $clog2(LIST_DEPTH);
  localparam int unsigned PTR_W = IDX_W + 1;

  generate
    if (LIST_DEPTH < 2 || LIST_DEPTH > 2048) begin : g_bad_depth
      $error("LIST_DEPTH must lie between 2 and 2048");
    end
  endgenerate

  // Bus slave: one setup cycle, answered in the first access cycle
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] regIdx;
  logic aligned, mapped, setup, wrEn;
  logic [31:0] rdVal;
  logic [55:0] wrWord;

  logic [23:0] upper_q, upper_d;
  logic [55:0] begin_q, begin_d, stop_q, stop_d, step_q, step_d;
  logic [31:0] dwell_q, dwell_d, cycles_q, cycles_d;
  slcr_pkg::slcr_ctrl_s ctrl_q, ctrl_d;

  slcr_pkg::slcr_load_e ld_q, ld_d;
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic [15:0] points_q, points_d;
  logic memWe;
  slcr_pkg::slcr_entry_s mem [LIST_DEPTH];

  slcr_pkg::slcr_seq_e sq_q, sq_d;
  logic [55:0] cur_q, cur_d, freq_q, freq_d;
  logic [53:0] amp_q, amp_d;
  logic [IDX_W-1:0] idx_q, idx_d, lastIdx;
  logic [31:0] cyc_q, cyc_d, cycNext, listDwell_q, listDwell_d, timerUnits;
  logic active_q, active_d, timerLoad, timerDone, seqDone, cycleEnd;
  logic startReq, stopReq;
  slcr_pkg::slcr_entry_s entry;
  slcr_pkg::slcr_status_s status;

  logic trigS1_q, trigS2_q, trigS3_q, trigStable_q, trigStable_d, trigEvent_q, trigEvent_d;

  assign regIdx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wrWord = {upper_q, pwdata};

  always_comb begin
    status = '0;
    status.points = points_q;
    status.active = active_q;
    status.terminated = (ld_q == slcr_pkg::LD_DONE);
    status.armed = (ld_q == slcr_pkg::LD_ARMED);
    status.ptr = slcr_pkg::PTR_STAT_W'(ptr_q);
  end

  // Write-only registers read back as zero; only own registers return data
  always_comb begin
    mapped = 1'b1;
    rdVal = 32'h0;
    case (regIdx)
      slcr_pkg::IDX_BEGIN, slcr_pkg::IDX_STOP, slcr_pkg::IDX_STEP, slcr_pkg::IDX_DWELL,
      slcr_pkg::IDX_CYCLES, slcr_pkg::IDX_RSVD, slcr_pkg::IDX_POINTS,
      slcr_pkg::IDX_LOAD: rdVal = 32'h0;
      slcr_pkg::IDX_UPPER: rdVal = {8'h0, upper_q};
      slcr_pkg::IDX_CTRL: rdVal = {28'h0, ctrl_q};
      slcr_pkg::IDX_STATUS: rdVal = status;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    pready_d = setup;
    pslverr_d = setup && !(aligned && mapped);
    prdata_d = (setup && !pwrite && aligned) ? rdVal : slcr_pkg::DATA_RESET;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= slcr_pkg::DATA_RESET;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // The upper 24 bits of every wide word are staged first, then the low word commits
  assign startReq = wrEn && (regIdx == slcr_pkg::IDX_CTRL) && pwdata[0];
  assign stopReq = wrEn && (regIdx == slcr_pkg::IDX_CTRL) && !pwdata[0];

  always_comb begin
    upper_d = upper_q;
    begin_d = begin_q;
    stop_d = stop_q;
    step_d = step_q;
    dwell_d = dwell_q;
    cycles_d = cycles_q;
    ctrl_d = ctrl_q;
    if (seqDone) begin
      ctrl_d.run = 1'b0;
    end
    if (wrEn) begin
      case (regIdx)
        slcr_pkg::IDX_UPPER: upper_d = pwdata[23:0];
        slcr_pkg::IDX_BEGIN: begin_d = wrWord;
        slcr_pkg::IDX_STOP: stop_d = wrWord; // RULE1
        slcr_pkg::IDX_STEP: step_d = wrWord; // RULE3
        slcr_pkg::IDX_DWELL: dwell_d = pwdata; // RULE4
        slcr_pkg::IDX_CYCLES: cycles_d = pwdata; // RULE5
        slcr_pkg::IDX_CTRL: ctrl_d = pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upper_q <= 24'h0;
      begin_q <= slcr_pkg::WORD_RESET;
      stop_q <= slcr_pkg::WORD_RESET;
      step_q <= slcr_pkg::WORD_RESET;
      dwell_q <= slcr_pkg::DATA_RESET;
      cycles_q <= slcr_pkg::DATA_RESET;
      ctrl_q <= slcr_pkg::CTRL_RESET;
    end else begin
      upper_q <= upper_d;
      begin_q <= begin_d;
      stop_q <= stop_d;
      step_q <= step_d;
      dwell_q <= dwell_d;
      cycles_q <= cycles_d;
      ctrl_q <= ctrl_d;
    end
  end

  // List loader
  always_comb begin
    ld_d = ld_q;
    ptr_d = ptr_q;
    points_d = points_q;
    memWe = 1'b0;
    if (wrEn && regIdx == slcr_pkg::IDX_POINTS) begin
      points_d = pwdata[15:0]; // RULE6
    end
    if (wrEn && regIdx == slcr_pkg::IDX_LOAD) begin
      if (wrWord == slcr_pkg::LOAD_RESET_WORD) begin
        ptr_d = '0; // RULE11
        ld_d = slcr_pkg::LD_ARMED;
      end else if (wrWord == slcr_pkg::LOAD_END_WORD) begin
        if (ld_q != slcr_pkg::LD_DONE) begin
          ld_d = slcr_pkg::LD_DONE; // RULE13
          points_d = 16'(ptr_q); // RULE14
        end
      end else if (ld_q == slcr_pkg::LD_ARMED && ptr_q < PTR_W'(LIST_DEPTH)) begin // RULE17
        memWe = 1'b1; // RULE12
        ptr_d = ptr_q + PTR_W'(1);
      end
      // A finished load ignores everything but a rewind (RULE17)
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ld_q <= slcr_pkg::LD_IDLE;
      ptr_q <= '0;
      points_q <= 16'h0;
    end else begin
      ld_q <= ld_d;
      ptr_q <= ptr_d;
      points_q <= points_d;
    end
  end

  // Table storage carries no reset; a load always rewinds first
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[ptr_q[IDX_W-1:0]] <= wrWord; // RULE9
    end
  end

  // Trigger pin: three stages, a new low level counts once stages two and three agree
  always_comb begin
    trigStable_d = trigStable_q;
    trigEvent_d = 1'b0;
    if (trigS2_q == trigS3_q && trigS3_q != trigStable_q) begin
      trigStable_d = trigS3_q;
      trigEvent_d = !trigS3_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigS1_q <= 1'b1;
      trigS2_q <= 1'b1;
      trigS3_q <= 1'b1;
      trigStable_q <= 1'b1;
      trigEvent_q <= 1'b0;
    end else begin
      trigS1_q <= trigPin;
      trigS2_q <= trigS1_q;
      trigS3_q <= trigS2_q;
      trigStable_q <= trigStable_d;
      trigEvent_q <= trigEvent_d;
    end
  end

  // Step sequencer
  assign entry = mem[idx_q];
  assign lastIdx = IDX_W'(points_q - 16'h1);
  assign timerUnits = ctrl_q.listMode ? listDwell_q : dwell_q;
  assign cycNext = cyc_q + 32'h1;

  always_comb begin
    if (ctrl_q.listMode) begin
      cycleEnd = ctrl_q.reverse ? (idx_q == '0) : (idx_q == lastIdx);
    end else if (ctrl_q.reverse) begin
      cycleEnd = (step_q == '0) || (cur_q <= begin_q) || ((cur_q - begin_q) < step_q);
    end else begin
      cycleEnd = (step_q == '0) || (cur_q >= stop_q) || ((stop_q - cur_q) < step_q);
    end
  end

  slcr_dwell_timer #(
    .TICK_CYCLES(DWELL_TICK_CYCLES)
  ) u_dwell (
    .clk(clk),
    .rstn(rstn),
    .load(timerLoad), // RULE16
    .units(timerUnits),
    .done(timerDone)
  );

  always_comb begin
    sq_d = sq_q;
    cur_d = cur_q;
    idx_d = idx_q;
    cyc_d = cyc_q;
    freq_d = freq_q;
    amp_d = amp_q;
    listDwell_d = listDwell_q;
    active_d = active_q;
    timerLoad = 1'b0;
    seqDone = 1'b0;
    unique case (sq_q)
      slcr_pkg::SQ_IDLE: begin
        if (startReq) begin
          if (pwdata[2] && points_q == 16'h0) begin
            seqDone = 1'b1;
          end else begin
            active_d = 1'b1;
            cyc_d = 32'h0;
            listDwell_d = dwell_q;
            cur_d = pwdata[1] ? stop_q : begin_q; // RULE15
            idx_d = pwdata[1] ? lastIdx : '0; // RULE15
            sq_d = slcr_pkg::SQ_SHOW;
          end
        end
      end
      slcr_pkg::SQ_SHOW: begin
        sq_d = slcr_pkg::SQ_NEXT;
        if (!ctrl_q.listMode) begin
          freq_d = cur_q;
          timerLoad = 1'b1;
          sq_d = slcr_pkg::SQ_WAIT;
        end else begin
          unique case (entry.tag) // RULE9
            slcr_pkg::TAG_FREQ: begin
              freq_d = {2'h0, entry.payload}; // RULE10
              timerLoad = 1'b1;
              sq_d = slcr_pkg::SQ_WAIT;
            end
            slcr_pkg::TAG_AMP: amp_d = entry.payload; // RULE10
            slcr_pkg::TAG_DWELL: listDwell_d = entry.payload[31:0];
            slcr_pkg::TAG_END: ;
          endcase
        end
      end
      slcr_pkg::SQ_WAIT: begin
        if (ctrl_q.stepOnTrig ? trigEvent_q : timerDone) begin
          sq_d = slcr_pkg::SQ_NEXT;
        end
      end
      slcr_pkg::SQ_NEXT: begin
        sq_d = slcr_pkg::SQ_SHOW;
        if (!cycleEnd) begin
          cur_d = ctrl_q.reverse ? cur_q - step_q : cur_q + step_q; // RULE15
          idx_d = ctrl_q.reverse ? idx_q - IDX_W'(1) : idx_q + IDX_W'(1);
        end else if (cycles_q != 32'h0 && cycNext == cycles_q) begin
          active_d = 1'b0; // RULE5
          seqDone = 1'b1;
          sq_d = slcr_pkg::SQ_IDLE;
        end else begin
          cyc_d = cycNext; // RULE5
          cur_d = ctrl_q.reverse ? stop_q : begin_q;
          idx_d = ctrl_q.reverse ? lastIdx : '0;
        end
      end
    endcase
    if (stopReq) begin
      active_d = 1'b0;
      sq_d = slcr_pkg::SQ_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sq_q <= slcr_pkg::SQ_IDLE;
      cur_q <= slcr_pkg::WORD_RESET;
      idx_q <= '0;
      cyc_q <= 32'h0;
      freq_q <= slcr_pkg::WORD_RESET;
      amp_q <= 54'h0;
      listDwell_q <= 32'h0;
      active_q <= 1'b0;
    end else begin
      sq_q <= sq_d;
      cur_q <= cur_d;
      idx_q <= idx_d;
      cyc_q <= cyc_d;
      freq_q <= freq_d;
      amp_q <= amp_d;
      listDwell_q <= listDwell_d;
      active_q <= active_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign freqMilliHz = freq_q;
  assign ampCentiDbm = amp_q;
  assign sweepActive = active_q;
endmodule // slcr_regs

/* File: dv/slcr_regs_sva.sv */
// Port checker for the sweep and list configuration registers
`timescale 1ns/1ps
module slcr_regs_sva #(
  parameter int unsigned LIST_DEPTH = slcr_pkg::LIST_DEPTH,
  parameter int unsigned DWELL_TICK_CYCLES = slcr_pkg::DWELL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigPin,
  input wire logic [55:0] freqMilliHz,
  input wire logic [53:0] ampCentiDbm,
  input wire logic sweepActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic ctrlWr;
  assign ctrlWr = psel && penable && pready && pwrite &&
                  paddr == {2'b00, slcr_pkg::IDX_CTRL, 2'b00};

  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_quiet_read_bus: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_misaligned_error: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access accepted");
  a_wo_read_zero: assert property (psel && !penable && !pwrite &&
      paddr[11:2] inside {[10'h006:10'h00d]} && paddr[1:0] == 2'b00 |=>
      prdata == 32'h0 && !pslverr)
    else $error("write-only register readable");
  a_start_raises_active: assert property (
      ctrlWr && pwdata[0] && !pwdata[2] && !sweepActive |-> ##[1:2] sweepActive)
    else $error("sweep did not start");
  a_stop_drops_active: assert property (ctrlWr && !pwdata[0] |-> ##[1:2] !sweepActive)
    else $error("sweep did not stop");
  a_idle_output_hold: assert property (
      !sweepActive && !$past(sweepActive) |-> $stable(freqMilliHz) && $stable(ampCentiDbm))
    else $error("outputs moved while idle");

  c_sweep_start: cover property (ctrlWr && pwdata[0]);
  c_bus_error: cover property (pslverr);
  c_sweep_end: cover property ($fell(sweepActive));
endmodule // slcr_regs_sva

bind slcr_regs slcr_regs_sva #(.LIST_DEPTH(LIST_DEPTH), .DWELL_TICK_CYCLES(DWELL_TICK_CYCLES))
  u_slcr_regs_sva (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trigPin(trigPin), .freqMilliHz(freqMilliHz), .ampCentiDbm(ampCentiDbm),
  .sweepActive(sweepActive));

/* File: dv/tb_sweep_list_config_regs.sv */
// Self-checking bench for the sweep and list configuration registers
`timescale 1ns/1ps
module tb_sweep_list_config_regs;
  localparam int unsigned DEPTH = 16;
  localparam int unsigned TICK = 4;
  logic clk, rstn, psel, penable, pwrite, trigPin, pready, pslverr, sweepActive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [55:0] freqMilliHz, lastFreq;
  logic [53:0] ampCentiDbm;
  int bad_count, compares, cycles, activeCycles;
  logic [55:0] seen[$];

  slcr_regs #(.LIST_DEPTH(DEPTH), .DWELL_TICK_CYCLES(TICK)) u_slcr_regs (.clk(clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigPin(trigPin),
    .freqMilliHz(freqMilliHz), .ampCentiDbm(ampCentiDbm), .sweepActive(sweepActive));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Log only real changes, so a stale value from the previous run is never counted
  always @(posedge clk) begin
    if (sweepActive === 1'b1) activeCycles++;
    if (sweepActive === 1'b1 && freqMilliHz !== lastFreq) seen.push_back(freqMilliHz);
    lastFreq <= freqMilliHz;
    cycles++;
    if (cycles > 40000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
  end

  // One idle edge after each transfer keeps a driver from assigning twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk(56'(n), 56'h1, "ready delay");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {2'b00, idx, 2'b00}, d, r, e);
    chk({55'h0, e}, 56'h0, "write error");
  endtask

  task automatic wr56(input logic [7:0] idx, input logic [55:0] v);
    wr(slcr_pkg::IDX_UPPER, {8'h00, v[55:32]});
    wr(idx, v[31:0]);
  endtask

  // Armed bit is masked once terminated: its value there is left to the design
  task automatic stat(input int pts, input bit arm, input bit term, input int ptr);
    logic [31:0] r;
    logic e;
    apb(1'b0, {2'b00, slcr_pkg::IDX_STATUS, 2'b00}, 32'h0, r, e);
    if (term) r[12] = 1'b0;
    chk({24'h0, r}, {24'h0, 16'(pts), 2'b00, term, arm, 12'(ptr)}, "status");
  endtask

  task automatic run(input logic [31:0] ctrl, input logic [55:0] ex[$], input int u);
    int n;
    seen.delete();
    activeCycles = 0;
    wr(slcr_pkg::IDX_CTRL, ctrl);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sweepActive === 1'b1 || n < 3) && n < 5000);
    chk(56'(seen.size()), 56'(ex.size()), "step count");
    foreach (ex[i]) chk(seen[i], ex[i], "step frequency");
    chk(56'(activeCycles >= ex.size() * u * TICK &&
            activeCycles <= 2 * ex.size() * (u * TICK + 8) + 8), 56'h1, "run length");
  endtask

  initial begin
    logic [55:0] b, s;
    logic [55:0] ex[$];
    logic [55:0] w[4];
    logic [31:0] r;
    logic e;
    void'($urandom(32'h5be9f184));
    {psel, penable, pwrite, rstn} = 4'h0;
    trigPin = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    lastFreq = 56'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 6; i <= 13; i++) begin
      apb(1'b0, {2'b00, 8'(i), 2'b00}, 32'h0, r, e);
      chk({23'h0, e, r}, 56'h0, "write-only read");
    end
    apb(1'b1, 12'h0c1, 32'h1, r, e);
    chk({55'h0, e}, 56'h1, "misaligned");
    apb(1'b0, 12'h0c0, 32'h0, r, e);
    chk({55'h0, e}, 56'h1, "unmapped");
    w[0] = {slcr_pkg::TAG_FREQ, 22'h0, $urandom | 32'h1};
    w[1] = {slcr_pkg::TAG_AMP, 38'h0, 16'($urandom) | 16'h1};
    w[2] = w[0] + 56'd5;
    w[3] = {slcr_pkg::TAG_AMP, 38'h0, 16'($urandom) | 16'h1};
    wr56(slcr_pkg::IDX_LOAD, slcr_pkg::LOAD_RESET_WORD);
    stat(0, 1, 0, 0);
    for (int i = 0; i < 4; i++) wr56(slcr_pkg::IDX_LOAD, w[i]);
    stat(0, 1, 0, 4);
    wr56(slcr_pkg::IDX_LOAD, slcr_pkg::LOAD_END_WORD);
    stat(4, 0, 1, 4);
    wr56(slcr_pkg::IDX_LOAD, w[1]);
    stat(4, 0, 1, 4);
    wr(slcr_pkg::IDX_POINTS, 32'h2);
    stat(2, 0, 1, 4);
    wr(slcr_pkg::IDX_DWELL, 32'h2);
    wr(slcr_pkg::IDX_CYCLES, 32'h1);
    ex = '{{2'h0, w[0][53:0]}};
    run(32'h5, ex, 2);
    chk({2'h0, ampCentiDbm}, {2'h0, w[1][53:0]}, "amplitude");
    wr(slcr_pkg::IDX_POINTS, 32'h4);
    ex = '{{2'h0, w[2][53:0]}, {2'h0, w[0][53:0]}};
    run(32'h7, ex, 2);
    for (int k = 0; k < 3; k++) begin
      b = {8'(k + 1), 16'($urandom), 32'($urandom)};
      s = {24'h0, $urandom | 32'h1};
      wr56(slcr_pkg::IDX_BEGIN, b);
      wr56(slcr_pkg::IDX_STOP, b + 3 * s);
      wr56(slcr_pkg::IDX_STEP, s);
      wr(slcr_pkg::IDX_DWELL, 32'(k));
      wr(slcr_pkg::IDX_CYCLES, (k == 1) ? 32'h2 : 32'h1);
      ex.delete();
      repeat ((k == 1) ? 2 : 1) for (int j = 0; j < 4; j++)
        ex.push_back((k == 0) ? b + (3 - j) * s : b + j * s);
      run({30'h0, k == 0, 1'b1}, ex, k);
    end
    // Step on trigger: four falling edges walk the last sweep once
    ex.delete();
    for (int j = 0; j < 4; j++) ex.push_back(b + j * s);
    fork
      run(32'h9, ex, 3);
      repeat (4) begin
        repeat (8) @(posedge clk);
        trigPin <= 1'b0;
        repeat (8) @(posedge clk);
        trigPin <= 1'b1;
      end
    join
    wr56(slcr_pkg::IDX_LOAD, slcr_pkg::LOAD_RESET_WORD);
    for (int i = 1; i <= DEPTH + 2; i++) wr56(slcr_pkg::IDX_LOAD, 56'(i));
    wr56(slcr_pkg::IDX_LOAD, slcr_pkg::LOAD_END_WORD);
    stat(DEPTH, 0, 1, DEPTH);
    wr(slcr_pkg::IDX_CYCLES, 32'h0);
    wr(slcr_pkg::IDX_CTRL, 32'h1);
    repeat (300) @(posedge clk);
    chk({55'h0, sweepActive}, 56'h1, "endless sweep");
    wr(slcr_pkg::IDX_CTRL, 32'h0);
    chk({55'h0, sweepActive}, 56'h0, "sweep stop");
    stop_test();
  end
endmodule // tb_sweep_list_config_regs
